// File: core/iahp_consts.svh
`ifndef IAHP_CONSTS_SVH
`define IAHP_CONSTS_SVH

// clock and timing
`define IAHP_CLK_KHZ 10000
`define IAHP_ACCESS_NS 900
`define IAHP_ACCESS_MAX_CYC ((`IAHP_ACCESS_NS * `IAHP_CLK_KHZ) / 1000000)
`define IAHP_EXEC_CYC 4'h3
`define IAHP_FINISH_CYC 4'h2

// mode register fields and reset value
`define IAHP_MOD_RESET 8'hff
`define IAHP_MOD_WIPE_N 7
`define IAHP_MOD_ABORT 6
`define IAHP_MOD_STANDBY 5
`define IAHP_MOD_LMODE_HI 4
`define IAHP_MOD_LMODE_LO 1
`define IAHP_MOD_TRISTATE 0

// control byte fields
`define IAHP_CTRL_TYPE_HI 5
`define IAHP_CTRL_TYPE_LO 4
`define IAHP_CTRL_READ 0
`define IAHP_CTRL_ONES 8'hcc

// indirect register addresses and values
`define IAHP_ADDR_SETUP 8'hfe
`define IAHP_ADDR_SHIFT 8'hff
`define IAHP_SETUP_RESET 2'h3
`define IAHP_SETUP_PAD 6'h3f
`define IAHP_SETUP_STD 0
`define IAHP_SETUP_RATE 1
`define IAHP_SHIFT_RESET 8'h00

// connection store
`define IAHP_CM_WIPE_VAL 10'h200
`define IAHP_CM_LAST 8'hff
`define IAHP_STA_LOW 5'h00

`endif

// File: core/iahp_pkg.sv
package iahp_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_EXEC,
		SEQ_READY,
		SEQ_FINISH
	} iahp_seq_t;

	// byte pointer into the window
	typedef enum logic [1:0] {
		PTR_CTRL,
		PTR_DATA,
		PTR_ADDR
	} iahp_ptr_t;

	// decoded access kinds
	typedef enum logic [1:0] {
		KIND_MEM_RD,
		KIND_MEM_WR,
		KIND_REG_RD,
		KIND_REG_WR
	} iahp_kind_t;

	// strobe events from the host port
	typedef struct packed {
		logic wr_start;
		logic rd_start;
		logic rd_end;
		logic soft_reset;
	} iahp_strobe_t;

endpackage : iahp_pkg

// File: core/iahp_cstore.sv
`timescale 1ns/1ps
module iahp_cstore #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 10
) (
	// clock
	input wire logic sys_clk,
	// access port
	input wire logic we,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	output logic [DATA_W-1:0] rdata
);

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// single port, read data registered, no reset so it maps to ram
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule : iahp_cstore

// File: core/iahp_strobe.sv
`timescale 1ns/1ps
module iahp_strobe import iahp_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// host strobes, active low
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	// decoded events
	output iahp_strobe_t strobe
);

	logic wr_act;
	logic rd_act;
	logic wr_prev;
	logic rd_prev;

	// both strobes low is the software reset, not an access
	assign wr_act = ~cs_n & ~wr_n & rd_n;
	assign rd_act = ~cs_n & ~rd_n & wr_n;

	// previous strobe levels for edge detection
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_prev <= 1'b0;
			rd_prev <= 1'b0;
		end else begin
			wr_prev <= wr_act;
			rd_prev <= rd_act;
		end
	end

	// one-cycle access edges, software reset as a level; chip select plays no part in software reset
	assign strobe.wr_start = wr_act & ~wr_prev;
	assign strobe.rd_start = rd_act & ~rd_prev;
	assign strobe.rd_end = ~rd_act & rd_prev;
	assign strobe.soft_reset = ~wr_n & ~rd_n;

endmodule : iahp_strobe

// File: core/iahp_host_port.sv
`timescale 1ns/1ps
`include "iahp_consts.svh"
module iahp_host_port import iahp_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// host bus
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic register_select,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	// status input from the switching core
	input wire logic data_loss_warn,
	// configuration towards the switching core
	output logic [3:0] line_mode,
	output logic tristate_scheme,
	output logic standby,
	output logic primary_access,
	output logic clock_rate_sel,
	output logic [7:0] frame_shift,
	// busy flags
	output logic cm_reset_busy,
	output logic access_busy
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	iahp_strobe_t strobe;
	iahp_seq_t seq_state;
	iahp_ptr_t ptr;
	iahp_kind_t kind;
	logic [7:0] mode_control_reg;
	logic [1:0] setup_reg;
	logic [7:0] frame_shift_reg;
	logic [7:0] ctrl_byte;
	logic [7:0] data_byte;
	logic [7:0] addr_byte;
	logic busy_z;
	logic cm_busy;
	logic [7:0] wipe_addr;
	logic [3:0] seq_cnt;
	logic abort;
	logic iar_wr;
	logic mode_wr;
	logic exec_go;
	logic exec_last;
	logic mem_we;
	logic [7:0] mem_addr;
	logic [9:0] mem_wdata;
	logic [9:0] mem_rdata;
	logic [7:0] iar_byte;
	logic [7:0] reg_rdata;

	// access kind from the control byte type bits and read bit
	function automatic iahp_kind_t decode_kind(input logic [7:0] ctrl);
		logic [1:0] ty;
		ty = {ctrl[`IAHP_CTRL_TYPE_HI], ctrl[`IAHP_CTRL_TYPE_LO]};
		if (ty == 2'h0) begin
			decode_kind = KIND_MEM_RD;
		end else if (ty != 2'h3) begin
			decode_kind = KIND_MEM_WR;
		end else if (ctrl[`IAHP_CTRL_READ]) begin
			decode_kind = KIND_REG_RD;
		end else begin
			decode_kind = KIND_REG_WR;
		end
	endfunction : decode_kind

	// true for the kinds that return a result to the host
	function automatic logic is_read(input iahp_kind_t k);
		is_read = (k == KIND_MEM_RD) || (k == KIND_REG_RD);
	endfunction : is_read

	////////////////////////////////////////////////////////////////////////
	// strobe decoding and connection store

	iahp_strobe u_strobe (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.wr_n(wr_n),
		.rd_n(rd_n),
		.strobe(strobe)
	);

	// 10-bit words, address carries output line and slot
	iahp_cstore #(
		.ADDR_W(8),
		.DATA_W(10)
	) u_cstore (
		.sys_clk(sys_clk),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// access qualification

	// window writes only start or continue a request while idle
	assign abort = mode_control_reg[`IAHP_MOD_ABORT];
	assign iar_wr = strobe.wr_start & register_select & ~abort & (seq_state == SEQ_IDLE);
	assign mode_wr = strobe.wr_start & ~register_select;
	assign kind = decode_kind(ctrl_byte);
	// a wipe in progress owns the store, so the internal access waits
	assign exec_go = (seq_state == SEQ_EXEC) & ~cm_busy;
	assign exec_last = exec_go & (seq_cnt == 4'h1);

	// store port: wipe first, then the sequencer's own access
	always_comb begin
		mem_we = 1'b0;
		mem_addr = addr_byte;
		mem_wdata = {ctrl_byte[1:0], data_byte};
		if (cm_busy) begin
			mem_we = 1'b1;
			mem_addr = wipe_addr;
			mem_wdata = `IAHP_CM_WIPE_VAL;
		end else if (exec_go && seq_cnt == `IAHP_EXEC_CYC && kind == KIND_MEM_WR) begin
			mem_we = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode register

	// write only; software reset restores power-up ones
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_control_reg <= `IAHP_MOD_RESET;
		end else if (strobe.soft_reset) begin
			mode_control_reg <= `IAHP_MOD_RESET;
		end else if (mode_wr) begin
			mode_control_reg <= host_data_in;
		end
	end

	// line mode is passed as written; host keeps primary access legal
	assign line_mode = mode_control_reg[`IAHP_MOD_LMODE_HI:`IAHP_MOD_LMODE_LO];
	assign tristate_scheme = mode_control_reg[`IAHP_MOD_TRISTATE];
	assign standby = mode_control_reg[`IAHP_MOD_STANDBY];

	////////////////////////////////////////////////////////////////////////
	// connection store wipe

	// a zero in the wipe bit fills every word with the tristate code
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cm_busy <= 1'b0;
			wipe_addr <= 8'h00;
		end else if (mode_wr && !host_data_in[`IAHP_MOD_WIPE_N]) begin
			cm_busy <= 1'b1;
			wipe_addr <= 8'h00;
		end else if (cm_busy) begin
			wipe_addr <= wipe_addr + 8'h01;
			if (wipe_addr == `IAHP_CM_LAST) begin
				cm_busy <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// indirect registers

	// setup and shift registers written at the end of a register write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_reg <= `IAHP_SETUP_RESET;
			frame_shift_reg <= `IAHP_SHIFT_RESET;
		end else if (strobe.soft_reset) begin
			setup_reg <= `IAHP_SETUP_RESET;
			frame_shift_reg <= `IAHP_SHIFT_RESET;
		end else begin
			if (exec_last && kind == KIND_REG_WR && addr_byte == `IAHP_ADDR_SETUP) begin
				setup_reg <= data_byte[1:0];
			end
			// shift only matters in primary access, so it is held at zero otherwise
			if (setup_reg[`IAHP_SETUP_STD]) begin
				frame_shift_reg <= `IAHP_SHIFT_RESET;
			end else if (exec_last && kind == KIND_REG_WR && addr_byte == `IAHP_ADDR_SHIFT) begin
				frame_shift_reg <= data_byte;
			end
		end
	end

	assign primary_access = ~setup_reg[`IAHP_SETUP_STD];
	assign clock_rate_sel = setup_reg[`IAHP_SETUP_RATE];
	assign frame_shift = frame_shift_reg;

	// read value of the addressed indirect register
	always_comb begin
		if (addr_byte == `IAHP_ADDR_SETUP) begin
			reg_rdata = {`IAHP_SETUP_PAD, setup_reg};
		end else begin
			reg_rdata = frame_shift_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	// state, pointer, busy flag and the small timing counter
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_state <= SEQ_IDLE;
			ptr <= PTR_CTRL;
			busy_z <= 1'b0;
			seq_cnt <= 4'h0;
		end else if (strobe.soft_reset || abort) begin
			seq_state <= SEQ_IDLE;
			ptr <= PTR_CTRL;
			busy_z <= 1'b0;
			seq_cnt <= 4'h0;
		end else begin
			unique case (seq_state)
				SEQ_IDLE: begin
					if (iar_wr) begin
						unique case (ptr)
							PTR_CTRL: begin
								busy_z <= 1'b1;
								ptr <= PTR_DATA;
							end
							PTR_DATA: begin
								ptr <= PTR_ADDR;
							end
							default: begin
								ptr <= PTR_CTRL;
								seq_state <= SEQ_EXEC;
								seq_cnt <= `IAHP_EXEC_CYC;
							end
						endcase
					end
				end
				SEQ_EXEC: begin
					// with no wipe in progress, completes well inside the access time limit
					if (exec_go) begin
						seq_cnt <= seq_cnt - 4'h1;
						if (exec_last) begin
							busy_z <= 1'b0;
							seq_state <= is_read(kind) ? SEQ_READY : SEQ_IDLE;
						end
					end
				end
				SEQ_READY: begin
					if (strobe.rd_start && register_select && ptr == PTR_CTRL) begin
						busy_z <= 1'b1;
					end
					// step on the strobe's end so the byte stays put while read
					if (strobe.rd_end && register_select) begin
						unique case (ptr)
							PTR_CTRL: ptr <= PTR_DATA;
							PTR_DATA: ptr <= PTR_ADDR;
							default: begin
								ptr <= PTR_CTRL;
								seq_state <= SEQ_FINISH;
								seq_cnt <= `IAHP_FINISH_CYC;
							end
						endcase
					end
				end
				SEQ_FINISH: begin
					seq_cnt <= seq_cnt - 4'h1;
					if (seq_cnt == 4'h1) begin
						busy_z <= 1'b0;
						seq_state <= SEQ_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// window bytes

	// written bytes land by pointer; a read result overwrites data and the two low control bits
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_byte <= 8'h00;
			data_byte <= 8'h00;
			addr_byte <= 8'h00;
		end else if (iar_wr) begin
			unique case (ptr)
				PTR_CTRL: ctrl_byte <= host_data_in;
				PTR_DATA: data_byte <= host_data_in;
				default: addr_byte <= host_data_in;
			endcase
		end else if (exec_last && kind == KIND_MEM_RD) begin
			data_byte <= mem_rdata[7:0];
			ctrl_byte[1:0] <= mem_rdata[9:8];
		end else if (exec_last && kind == KIND_REG_RD) begin
			data_byte <= reg_rdata;
			ctrl_byte[1:0] <= 2'h3;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	// type bits and address keep their written values; unused bits as ones
	always_comb begin
		unique case (ptr)
			PTR_CTRL: iar_byte = ctrl_byte | `IAHP_CTRL_ONES;
			PTR_DATA: iar_byte = data_byte;
			default: iar_byte = addr_byte;
		endcase
	end

	// registered read data; status low bits are always zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_data_out <= 8'h00;
		end else if (register_select) begin
			host_data_out <= iar_byte;
		end else begin
			host_data_out <= {cm_busy, busy_z, data_loss_warn, `IAHP_STA_LOW};
		end
	end

	// drive the bus only for a plain read
	assign host_data_oe = ~cs_n & ~rd_n & wr_n;
	assign cm_reset_busy = cm_busy;
	assign access_busy = busy_z;

endmodule : iahp_host_port

// File: verif/iahp_host_monitor.sv
`timescale 1ns/1ps
module iahp_host_monitor import iahp_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// host bus
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic register_select,
	input wire logic [7:0] host_data_in,
	input wire logic [7:0] host_data_out,
	input wire logic host_data_oe,
	// core side
	input wire logic data_loss_warn,
	input wire logic [3:0] line_mode,
	input wire logic tristate_scheme,
	input wire logic standby,
	input wire logic primary_access,
	input wire logic clock_rate_sel,
	input wire logic [7:0] frame_shift,
	input wire logic cm_reset_busy,
	input wire logic access_busy
);
	logic w_act, r_act, w_q, r_q, ws, re, mw, abort_q;
	logic [1:0] wcnt, rcnt;

	// strobe edges; counts assume the host sends whole sequences
	assign w_act = !cs_n && !wr_n && rd_n;
	assign r_act = !cs_n && !rd_n && wr_n;
	assign ws = w_act && !w_q;
	assign re = r_q && !r_act;
	assign mw = ws && !register_select;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_q <= 1'h0;
			r_q <= 1'h0;
			abort_q <= 1'h1;
		end else begin
			w_q <= w_act;
			r_q <= r_act;
			abort_q <= (!wr_n && !rd_n) ? 1'h1 : (mw ? host_data_in[6] : abort_q);
		end
	end

	// byte counters, cleared where the sequencer is forced idle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wcnt <= 2'h0;
			rcnt <= 2'h0;
		end else if ((!wr_n && !rd_n) || (mw && host_data_in[6])) begin
			wcnt <= 2'h0;
			rcnt <= 2'h0;
		end else if (!abort_q) begin
			if (ws && register_select) wcnt <= (wcnt == 2'h2) ? 2'h0 : wcnt + 2'h1;
			if (re && register_select) rcnt <= (rcnt == 2'h2) ? 2'h0 : rcnt + 2'h1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	busy_set_a: assert property (ws && register_select && wcnt == 2'h0 && !abort_q |=> access_busy)
		else $error("busy not set by first window write");
	exec_bound_a: assert property (ws && register_select && wcnt == 2'h2 && !abort_q |-> ##[1:9] !access_busy)
		else $error("busy held too long after third write");
	read_set_a: assert property (r_act && !r_q && register_select && rcnt == 2'h0 && !abort_q |=> access_busy)
		else $error("busy not set by first result read");
	read_done_a: assert property (re && register_select && rcnt == 2'h2 && !abort_q |-> ##[1:9] !access_busy)
		else $error("busy held too long after third read");
	abort_clear_a: assert property (mw && host_data_in[6] |-> ##[1:2] !access_busy)
		else $error("abort did not clear busy");
	mode_out_a: assert property (mw |=> line_mode == $past(host_data_in[4:1]) && standby == $past(host_data_in[5]) && tristate_scheme == $past(host_data_in[0]))
		else $error("mode outputs do not follow write");
	wipe_start_a: assert property (mw && !host_data_in[7] |=> cm_reset_busy)
		else $error("wipe busy not set");
	shift_zero_a: assert property (!primary_access && !$past(primary_access) |-> frame_shift == 8'h00)
		else $error("shift register not zero in standard setup");
	status_low_a: assert property (r_act && r_q && !register_select |-> host_data_out[4:0] == 5'h00)
		else $error("status low bits not zero");
	oe_drive_a: assert property (host_data_oe == (!cs_n && !rd_n && wr_n))
		else $error("data enable does not match read strobe");

	cover property (re && register_select && rcnt == 2'h2);
	cover property (mw && !host_data_in[7]);
	cover property (mw && host_data_in[6] && access_busy);
endmodule : iahp_host_monitor

// File: verif/iahp_host_model.sv
`timescale 1ns/1ps
module iahp_host_model (
	// clock
	input wire logic sys_clk,
	// read data from the port
	input wire logic [7:0] host_data_out,
	// strobes and data towards the port
	output logic cs_n,
	output logic wr_n,
	output logic rd_n,
	output logic register_select,
	output logic [7:0] host_data_in
);
	initial begin
		{cs_n, wr_n, rd_n, register_select} = 4'hf;
		host_data_in = 8'h00;
	end

	// one byte write; released bus shows the inverse, never a stale copy
	task automatic write_byte(input logic s, input logic [7:0] d);
		@(negedge sys_clk);
		register_select = s;
		host_data_in = d;
		cs_n = 1'h0;
		wr_n = 1'h0;
		@(negedge sys_clk);
		cs_n = 1'h1;
		wr_n = 1'h1;
		host_data_in = ~d;
		@(negedge sys_clk);
	endtask : write_byte

	// one byte read; the output is registered, so sample after two edges
	task automatic read_byte(input logic s, output logic [7:0] d);
		@(negedge sys_clk);
		register_select = s;
		cs_n = 1'h0;
		rd_n = 1'h0;
		repeat (2) @(negedge sys_clk);
		d = host_data_out;
		cs_n = 1'h1;
		rd_n = 1'h1;
		@(negedge sys_clk);
	endtask : read_byte

	// both strobes low together, chip select ignored
	task automatic soft_reset();
		@(negedge sys_clk);
		{wr_n, rd_n} = 2'h0;
		@(negedge sys_clk);
		{wr_n, rd_n} = 2'h3;
		@(negedge sys_clk);
	endtask : soft_reset
endmodule : iahp_host_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
	typedef struct packed {logic [7:0] m; logic [3:0] lm; logic sb; logic ts;} iahp_row_t;
	logic sys_clk, rst_n, cs_n, wr_n, rd_n, register_select, data_loss_warn;
	logic host_data_oe, tristate_scheme, standby, primary_access, clock_rate_sel;
	logic cm_reset_busy, access_busy;
	logic [7:0] host_data_in, host_data_out, frame_shift, v;
	logic [3:0] line_mode;
	int fail_count, checked, n;
	iahp_row_t rows [4] = '{'{8'hbf, 4'hf, 1'h1, 1'h1}, '{8'h80, 4'h0, 1'h0, 1'h0},
		'{8'ha5, 4'h2, 1'h1, 1'h1}, '{8'h94, 4'ha, 1'h0, 1'h0}};

	iahp_host_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n),
		.rd_n(rd_n), .register_select(register_select), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.data_loss_warn(data_loss_warn), .line_mode(line_mode),
		.tristate_scheme(tristate_scheme), .standby(standby),
		.primary_access(primary_access), .clock_rate_sel(clock_rate_sel),
		.frame_shift(frame_shift), .cm_reset_busy(cm_reset_busy), .access_busy(access_busy));
	iahp_host_model hm (.sys_clk(sys_clk), .host_data_out(host_data_out), .cs_n(cs_n),
		.wr_n(wr_n), .rd_n(rd_n), .register_select(register_select),
		.host_data_in(host_data_in));

	initial sys_clk = 1'h0;
	always #50 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	// bounded wait for the access flag to drop
	task automatic idle_wait(input int lim);
		n = 0;
		while (access_busy !== 1'h0 && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
	endtask : idle_wait

	task automatic seq3(input logic [7:0] c, input logic [7:0] d, input logic [7:0] a);
		hm.write_byte(1'h1, c);
		`CHK("busy first byte", 1'h1, access_busy)
		hm.write_byte(1'h1, d);
		hm.write_byte(1'h1, a);
		idle_wait(8);
		`CHK("busy after access", 1'h0, access_busy)
	endtask : seq3

	task automatic res3(input logic [7:0] c, input logic [7:0] d, input logic [7:0] a);
		hm.read_byte(1'h1, v);
		`CHK("result control", c, v)
		`CHK("busy first read", 1'h1, access_busy)
		hm.read_byte(1'h1, v);
		`CHK("result data", d, v)
		hm.read_byte(1'h1, v);
		`CHK("result address", a, v)
		idle_wait(8);
		`CHK("busy after result", 1'h0, access_busy)
	endtask : res3

	// hang guard, far beyond the few hundred cycles the tests take
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'h0;
		data_loss_warn = 1'h1;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'h1;
		@(negedge sys_clk);
		`CHK("reset outputs", 18'h3f400, {line_mode, standby, tristate_scheme, primary_access, clock_rate_sel, frame_shift, cm_reset_busy, access_busy})
		hm.read_byte(1'h0, v);
		`CHK("status", 8'h20, v)
		$display("test reset done");
		foreach (rows[i]) begin
			hm.write_byte(1'h0, rows[i].m);
			`CHK("mode outputs", {rows[i].lm, rows[i].sb, rows[i].ts}, {line_mode, standby, tristate_scheme})
		end
		$display("test mode rows done");
		// memory writes then reads: type 01 and 10, unused bits zero
		seq3(8'h12, 8'h00, 8'haa);
		seq3(8'h01, 8'hff, 8'haa);
		res3(8'hce, 8'h00, 8'haa);
		seq3(8'h21, 8'h3c, 8'h10);
		seq3(8'h00, 8'h00, 8'h10);
		res3(8'hcd, 8'h3c, 8'h10);
		$display("test memory done");
		seq3(8'h30, 8'h55, 8'hff);
		`CHK("shift standard", 8'h00, frame_shift)
		seq3(8'h31, 8'h00, 8'hff);
		res3(8'hff, 8'h00, 8'hff);
		seq3(8'h30, 8'h00, 8'hfe);
		`CHK("setup outputs", 2'h2, {primary_access, clock_rate_sel})
		seq3(8'h30, 8'h55, 8'hff);
		`CHK("shift primary", 8'h55, frame_shift)
		seq3(8'h31, 8'h00, 8'hfe);
		res3(8'hff, 8'hfc, 8'hfe);
		seq3(8'h31, 8'h00, 8'hff);
		res3(8'hff, 8'h55, 8'hff);
		$display("test registers done");
		hm.write_byte(1'h1, 8'h12);
		hm.write_byte(1'h0, 8'hd4);
		@(negedge sys_clk);
		`CHK("busy after abort", 1'h0, access_busy)
		hm.write_byte(1'h0, 8'h94);
		seq3(8'h11, 8'h66, 8'h55);
		seq3(8'h00, 8'h00, 8'h55);
		res3(8'hcd, 8'h66, 8'h55);
		$display("test abort done");
		hm.write_byte(1'h0, 8'h14);
		`CHK("wipe busy", 1'h1, cm_reset_busy)
		// status while wiping, warning dropped so only the wipe flag is set
		data_loss_warn = 1'h0;
		hm.read_byte(1'h0, v);
		`CHK("status wipe", 8'h80, v)
		n = 0;
		while (cm_reset_busy !== 1'h0 && n < 300) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK("wipe done", 1'h0, cm_reset_busy)
		seq3(8'h00, 8'h00, 8'h55);
		res3(8'hce, 8'h00, 8'h55);
		$display("test wipe done");
		hm.soft_reset();
		`CHK("soft reset", 13'h1e00, {line_mode, primary_access, frame_shift})
		$display("test soft reset done");
		test_done();
	end
endmodule : tb_top

bind iahp_host_port iahp_host_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
	.wr_n(wr_n), .rd_n(rd_n), .register_select(register_select),
	.host_data_in(host_data_in), .host_data_out(host_data_out),
	.host_data_oe(host_data_oe), .data_loss_warn(data_loss_warn), .line_mode(line_mode),
	.tristate_scheme(tristate_scheme), .standby(standby), .primary_access(primary_access),
	.clock_rate_sel(clock_rate_sel), .frame_shift(frame_shift),
	.cm_reset_busy(cm_reset_busy), .access_busy(access_busy));
